// File: src/irc_controller.sv
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module irc_controller (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [13:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        basic_timer_interrupt_i,
  input  wire logic        gate_interrupt_i,
  input  wire logic        watch_interrupt_i,
  input  wire logic [7:0]  timer_zero_count_i,
  input  wire logic [7:0]  timer_zero_reference_i,
  input  wire logic        pin_interrupt_zero_i,
  input  wire logic        pin_interrupt_one_i,
  input  wire logic [3:0]  key_input_i,
  input  wire logic        comparator_zero_output_i,
  input  wire logic        comparator_one_output_i,
  input  wire logic        voltage_detect_output_i,
  input  wire logic        cpu_clk_tick_i,
  input  wire logic        sys_div64_tick_i,
  input  wire logic        fc_resume_i,
  input  wire logic        svc_ack_i,
  input  wire logic [2:0]  svc_id_i,
  output logic             irq_o,
  output logic      [2:0]  irq_id_o,
  output logic      [7:0]  pending_o,
  output logic             fc_clear_o
);

  localparam int NCH = 9;

  irc_pkg::irc_state_s st;
  irc_pkg::irc_state_s next_st;

  logic [NCH-1:0] ch_sample;
  logic [NCH-1:0] ch_level;
  logic [NCH-1:0] ch_rise;
  logic [NCH-1:0] ch_fall;
  logic [NCH-1:0] ch_event;

  // Pin 0 mode code to {rise, fall}
  function automatic logic [1:0] pin_edges(input logic [1:0] mode);
    logic [1:0] re;
    re = 2'h0;
    case (mode)
      2'h0: re = 2'h2;
      2'h1: re = 2'h1;
      2'h2: re = 2'h3;
      default: re = 2'h0;
    endcase
    return re;
  endfunction : pin_edges

  // Analog field code to {rise, fall}
  function automatic logic [1:0] ana_edges(input logic [1:0] mode);
    logic [1:0] re;
    re = 2'h0;
    case (mode)
      2'h1: re = 2'h1;
      2'h2: re = 2'h2;
      2'h3: re = 2'h3;
      default: re = 2'h0;
    endcase
    return re;
  endfunction : ana_edges

  // Codes 1..6 name a vectored source; 0 and 7 name none
  function automatic logic [5:0] code_mask(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    case (code)
      3'h1: m = 6'h01;
      3'h2: m = 6'h02;
      3'h3: m = 6'h04;
      3'h4: m = 6'h08;
      3'h5: m = 6'h10;
      3'h6: m = 6'h20;
      default: m = 6'h00;
    endcase
    return m;
  endfunction : code_mask

  // Status code limits which eligible sources may interrupt
  function automatic logic [5:0] serve_gate(input logic [5:0] elig,
                                            input logic [1:0] status,
                                            input logic [2:0] sel);
    logic [5:0] g;
    g = 6'h00;
    case (status)
      irc_pkg::ST_ALL:
        g = elig;
      irc_pkg::ST_HIGH:
        g = elig & code_mask(sel);
      default:
        g = 6'h00;
    endcase
    return g;
  endfunction : serve_gate

  // Enable above request, for one source
  function automatic logic [7:0] get_pair(input logic [7:0] en,
                                          input logic [7:0] req,
                                          input int         src);
    logic [7:0] d;
    d = {6'h00, en[src], req[src]};
    return d;
  endfunction : get_pair

  // Written enable and request of one source into {en, req}
  function automatic logic [15:0] put_pair(input logic [15:0] er,
                                           input int          src,
                                           input logic [1:0]  pair);
    logic [15:0] r;
    r = er;
    r[irc_pkg::NUM_SRC + src] = pair[1];
    r[src] = pair[0];
    return r;
  endfunction : put_pair

  // Code 1..6 of the source served first; 0 when none
  function automatic logic [2:0] pick(input logic [5:0] elig,
                                      input logic [2:0] sel);
    logic [2:0] code;
    code = 3'h0;
    for (int i = irc_pkg::NUM_VEC - 1; i >= 0; i--)
    begin
      if (elig[i])
        code = 3'(i + 1);
    end
    if ((elig & code_mask(sel)) != 6'h00)
      code = sel;
    return code;
  endfunction : pick

  function automatic logic [7:0] read_reg(input logic [11:0] idx,
                                          input irc_pkg::irc_state_s s);
    logic [7:0] d;
    d = 8'h00;
    case (idx)
      irc_pkg::IDX_FC_START:
        d = {4'h0, s.fc_start, 3'h0};
      irc_pkg::IDX_STATUS:
        d = {4'h0, s.status, 2'h0};
      irc_pkg::IDX_PRIORITY:
        d = {4'h0, s.priority_and_master_enable};
      irc_pkg::IDX_PIN0_MOD:
        d = {4'h0, s.pin_zero_edge_mode};
      irc_pkg::IDX_PIN1_MOD:
        d = {7'h00, s.pin_one_edge_mode};
      irc_pkg::IDX_KEY_MOD:
        d = {4'h0, s.key_edge_enables};
      irc_pkg::IDX_BT_ER:
        d = get_pair(s.en, s.req, irc_pkg::SRC_BT);
      irc_pkg::IDX_WATCH_ER:
        d = get_pair(s.en, s.req, irc_pkg::SRC_W);
      irc_pkg::IDX_ANA_ER:
        d = get_pair(s.en, s.req, irc_pkg::SRC_AN);
      irc_pkg::IDX_T0_ER:
        d = get_pair(s.en, s.req, irc_pkg::SRC_T0);
      irc_pkg::IDX_GATE_ER:
        d = get_pair(s.en, s.req, irc_pkg::SRC_G);
      irc_pkg::IDX_PIN_ER:
        d = {4'h0, s.en[irc_pkg::SRC_P1], s.req[irc_pkg::SRC_P1],
             s.en[irc_pkg::SRC_P0], s.req[irc_pkg::SRC_P0]};
      irc_pkg::IDX_KEY_ER:
        d = get_pair(s.en, s.req, irc_pkg::SRC_K);
      irc_pkg::IDX_ANA_MOD:
        d = {2'h0, s.analog_event_edge_mode};
      default:
        d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  // Edge channel setup: 0 pin0, 1 pin1, 2-5 keys, 6 vld, 7 c0, 8 c1
  always_comb
  begin
    ch_sample = {NCH{1'b1}};
    ch_sample[0] = st.pin_zero_edge_mode[irc_pkg::SAMPLE_BIT] ?
                   sys_div64_tick_i : cpu_clk_tick_i;
    ch_level = {comparator_one_output_i, comparator_zero_output_i,
                voltage_detect_output_i, key_input_i,
                pin_interrupt_one_i, pin_interrupt_zero_i};
    {ch_rise[0], ch_fall[0]} =
      pin_edges(st.pin_zero_edge_mode[1:0]);
    ch_rise[1] = ~st.pin_one_edge_mode;
    ch_fall[1] = st.pin_one_edge_mode;
    ch_rise[5:2] = 4'h0;
    ch_fall[5:2] = st.key_edge_enables;
    {ch_rise[6], ch_fall[6]} =
      ana_edges(st.analog_event_edge_mode[1:0]);
    {ch_rise[7], ch_fall[7]} =
      ana_edges(st.analog_event_edge_mode[3:2]);
    {ch_rise[8], ch_fall[8]} =
      ana_edges(st.analog_event_edge_mode[5:4]);
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_edge
    irc_edge_detect u_edge (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .sample_i  (ch_sample[g]),
      .level_i   (ch_level[g]),
      .rise_en_i (ch_rise[g]),
      .fall_en_i (ch_fall[g]),
      .event_o   (ch_event[g])
    );
  end

  always_comb
  begin
    logic        req_go;
    logic        wr;
    logic [11:0] idx;
    logic [7:0]  wd;
    logic        match;
    logic [7:0]  set_v;
    logic [7:0]  clr_v;
    logic [5:0]  elig;
    logic [5:0]  gated;
    req_go = 1'b0;
    wr = 1'b0;
    idx = 12'h000;
    wd = 8'h00;
    match = 1'b0;
    set_v = 8'h00;
    clr_v = 8'h00;
    elig = 6'h00;
    gated = 6'h00;
    next_st = st;

    // Answer one cycle after the request; write lands on the ack edge
    req_go = cyc_i & stb_i & ~st.ack;
    wr = cyc_i & stb_i & we_i & st.ack & sel_i[0];
    idx = adr_i[13:2];
    wd = dat_i[7:0];
    next_st.ack = req_go;
    next_st.rdat = req_go ? read_reg(idx, st) : 8'h00;

    if (wr)
    begin
      case (idx)
        irc_pkg::IDX_FC_START:
        begin
          if (wd[irc_pkg::FC_START_BIT])
          begin
            next_st.fc_start = 1'b1;
            clr_v[irc_pkg::SRC_G] = 1'b1;
          end
        end
        irc_pkg::IDX_STATUS:
          next_st.status = wd[irc_pkg::STATUS_LSB +: 2];
        irc_pkg::IDX_PRIORITY:
          next_st.priority_and_master_enable = wd[3:0];
        irc_pkg::IDX_PIN0_MOD:
          next_st.pin_zero_edge_mode = {wd[3], 1'b0, wd[1:0]};
        irc_pkg::IDX_PIN1_MOD:
          next_st.pin_one_edge_mode = wd[0];
        irc_pkg::IDX_KEY_MOD:
          next_st.key_edge_enables = wd[3:0];
        irc_pkg::IDX_ANA_MOD:
          next_st.analog_event_edge_mode = wd[5:0];
        irc_pkg::IDX_BT_ER:
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_BT, wd[1:0]);
        irc_pkg::IDX_WATCH_ER:
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_W, wd[1:0]);
        irc_pkg::IDX_ANA_ER:
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_AN, wd[1:0]);
        irc_pkg::IDX_T0_ER:
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_T0, wd[1:0]);
        irc_pkg::IDX_GATE_ER:
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_G, wd[1:0]);
        irc_pkg::IDX_PIN_ER:
        begin
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_P1, wd[3:2]);
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_P0, wd[1:0]);
        end
        irc_pkg::IDX_KEY_ER:
          {next_st.en, next_st.req} =
            put_pair({next_st.en, next_st.req}, irc_pkg::SRC_K, wd[1:0]);
        default:
          next_st.priority_and_master_enable = st.priority_and_master_enable;
      endcase
    end

    // Start bit drops once the counter reports it is running again
    if (fc_resume_i && !(wr && idx == irc_pkg::IDX_FC_START))
      next_st.fc_start = 1'b0;

    // Timer-0 match raises the flag once per match
    match = timer_zero_count_i == timer_zero_reference_i;
    next_st.t0_match = match;

    set_v[irc_pkg::SRC_BT] = basic_timer_interrupt_i;
    set_v[irc_pkg::SRC_P0] = ch_event[0];
    set_v[irc_pkg::SRC_P1] = ch_event[1];
    set_v[irc_pkg::SRC_G]  = gate_interrupt_i;
    set_v[irc_pkg::SRC_T0] = match & ~st.t0_match;
    set_v[irc_pkg::SRC_AN] = |ch_event[8:6];
    set_v[irc_pkg::SRC_W]  = watch_interrupt_i;
    set_v[irc_pkg::SRC_K]  = |ch_event[5:2];

    // Service clears only vectored sources; quasi flags stay
    if (svc_ack_i)
      clr_v[irc_pkg::NUM_VEC-1:0] =
        clr_v[irc_pkg::NUM_VEC-1:0] | code_mask(svc_id_i);

    // New events win over any clear in the same cycle
    next_st.req = (next_st.req & ~clr_v) | set_v;

    // Pending needs flag, enable and master enable
    next_st.pend = next_st.req & next_st.en &
                   {irc_pkg::NUM_SRC{next_st.priority_and_master_enable[irc_pkg::IME_BIT]}};
    elig = next_st.pend[irc_pkg::NUM_VEC-1:0];

    gated = serve_gate(elig, next_st.status,
                       next_st.priority_and_master_enable[2:0]);

    next_st.irq = |gated;
    next_st.irq_id = pick(gated, next_st.priority_and_master_enable[2:0]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= irc_pkg::STATE_RST;
    else
      st <= next_st;
  end

  assign dat_o      = {24'h000000, st.rdat};
  assign ack_o      = st.ack;
  assign irq_o      = st.irq;
  assign irq_id_o   = st.irq_id;
  assign pending_o  = st.pend;
  assign fc_clear_o = st.fc_start;

endmodule : irc_controller

// File: src/irc_edge_detect.sv
`timescale 1ns/1ps
module irc_edge_detect (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sample_i,
  input  wire logic level_i,
  input  wire logic rise_en_i,
  input  wire logic fall_en_i,
  output logic      event_o
);

  irc_pkg::irc_edge_s st;
  irc_pkg::irc_edge_s next_st;

  // First sample after reset only primes, so no false edge
  always_comb
  begin
    next_st = st;
    event_o = 1'b0;
    if (sample_i)
    begin
      next_st.sampled = level_i;
      next_st.primed  = 1'b1;
      event_o = st.primed &
                ((rise_en_i & level_i & ~st.sampled) |
                 (fall_en_i & ~level_i & st.sampled));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= irc_pkg::EDGE_RST;
    else
      st <= next_st;
  end

endmodule : irc_edge_detect

// File: src/irc_pkg.sv
package irc_pkg;

  localparam int ADR_W = 14;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_FC_START = 12'hFA0;
  localparam logic [11:0] IDX_STATUS   = 12'hFB0;
  localparam logic [11:0] IDX_PRIORITY = 12'hFB2;
  localparam logic [11:0] IDX_PIN0_MOD = 12'hFB4;
  localparam logic [11:0] IDX_PIN1_MOD = 12'hFB5;
  localparam logic [11:0] IDX_KEY_MOD  = 12'hFB6;
  localparam logic [11:0] IDX_BT_ER    = 12'hFB8;
  localparam logic [11:0] IDX_WATCH_ER = 12'hFBA;
  localparam logic [11:0] IDX_ANA_ER   = 12'hFBB;
  localparam logic [11:0] IDX_T0_ER    = 12'hFBC;
  localparam logic [11:0] IDX_GATE_ER  = 12'hFBD;
  localparam logic [11:0] IDX_PIN_ER   = 12'hFBE;
  localparam logic [11:0] IDX_KEY_ER   = 12'hFBF;
  localparam logic [11:0] IDX_ANA_MOD  = 12'hFD8;

  // Source positions in the flag vectors
  localparam int SRC_BT  = 0;
  localparam int SRC_P0  = 1;
  localparam int SRC_P1  = 2;
  localparam int SRC_G   = 3;
  localparam int SRC_T0  = 4;
  localparam int SRC_AN  = 5;
  localparam int SRC_W   = 6;
  localparam int SRC_K   = 7;
  localparam int NUM_SRC = 8;
  localparam int NUM_VEC = 6;

  // Field positions
  localparam int FC_START_BIT = 3;
  localparam int SAMPLE_BIT   = 3;
  localparam int IME_BIT      = 3;
  localparam int STATUS_LSB   = 2;

  // Status codes
  localparam logic [1:0] ST_ALL  = 2'h0;
  localparam logic [1:0] ST_HIGH = 2'h1;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdat;
    logic [3:0] priority_and_master_enable;
    logic [3:0] pin_zero_edge_mode;
    logic       pin_one_edge_mode;
    logic [3:0] key_edge_enables;
    logic [5:0] analog_event_edge_mode;
    logic [7:0] en;
    logic [7:0] req;
    logic [1:0] status;
    logic       fc_start;
    logic       t0_match;
    logic       irq;
    logic [2:0] irq_id;
    logic [7:0] pend;
  } irc_state_s;

  typedef struct packed {
    logic sampled;
    logic primed;
  } irc_edge_s;

  localparam irc_state_s STATE_RST = '0;
  localparam irc_edge_s  EDGE_RST  = '0;

endpackage : irc_pkg

// File: verification/irc_controller_props.sv
`timescale 1ns/1ps
module irc_controller_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        basic_timer_interrupt_i,
  input wire logic        svc_ack_i,
  input wire logic [2:0]  svc_id_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic [2:0]  irq_id_o,
  input wire logic [7:0]  pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held over one cycle");
  property p_ack_req; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_dat_hi; dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi)
    else $error("upper read bits set");
  property p_irq_pend; irq_o |-> pending_o[irq_id_o - 3'h1]; endproperty
  a_irq_pend: assert property (p_irq_pend)
    else $error("irq source not pending");
  property p_irq_id; irq_o |-> irq_id_o inside {[3'h1:3'h6]}; endproperty
  a_irq_id: assert property (p_irq_id)
    else $error("irq code out of range");
  property p_watch_hold;
    pending_o[6] && !cyc_i && !$past(cyc_i) |=> pending_o[6];
  endproperty
  a_watch_hold: assert property (p_watch_hold)
    else $error("watch flag dropped by hardware");
  property p_svc_clear;
    svc_ack_i && svc_id_i == 3'h1 && !basic_timer_interrupt_i && !cyc_i
      |=> !pending_o[0];
  endproperty
  a_svc_clear: assert property (p_svc_clear)
    else $error("basic flag not cleared by service");

  c_irq: cover property (irq_o);
  c_svc_gate: cover property (svc_ack_i && svc_id_i == 3'h4);
  c_watch: cover property (pending_o[6]);
endmodule : irc_controller_props

// File: verification/irc_core_model.sv
`timescale 1ns/1ps
module irc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  input  wire logic [2:0] id_i,
  input  wire logic [7:0] delay_i,
  output logic            ack_o,
  output logic      [2:0] id_o
);
  logic [7:0] wait_cnt;
  // Serves vectored codes only; quasi flags stay for software
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    if (rst_i)
      id_o <= 3'h0;
    if (rst_i || !irq_i || ack_o)
      wait_cnt <= 8'h00;
    else if (wait_cnt >= delay_i)
    begin
      ack_o <= 1'b1;
      id_o <= id_i;
    end
    else
      wait_cnt <= wait_cnt + 8'h01;
  end
endmodule : irc_core_model

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [13:0] adr_i = 14'h0000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [8:0]  lvl = 9'h000;
  logic [3:0]  ev = 4'h0;
  logic [7:0]  cnt = 8'h00;
  logic [7:0]  tref = 8'h00;
  logic [7:0]  dly = 8'h00;
  logic [2:0]  dv = 3'h0;
  logic [15:0] seed = 16'hD963;
  logic [19:0] n;
  logic [19:0] q[$];
  int          bad_count = 0;
  int          total_checks = 0;
  wire [31:0]  dat_o;
  wire         ack_o, irq_o, fc_clear_o, svc_ack_i;
  wire [2:0]   irq_id_o, svc_id_i;
  wire [7:0]   pending_o;
  wire         basic_timer_interrupt_i = ev[0];
  wire         gate_interrupt_i = ev[1];
  wire         watch_interrupt_i = ev[2];
  wire         fc_resume_i = ev[3];
  wire [7:0]   timer_zero_count_i = cnt;
  wire [7:0]   timer_zero_reference_i = tref;
  wire         pin_interrupt_zero_i = lvl[0];
  wire         pin_interrupt_one_i = lvl[1];
  wire [3:0]   key_input_i = lvl[5:2];
  wire         comparator_zero_output_i = lvl[6];
  wire         comparator_one_output_i = lvl[7];
  wire         voltage_detect_output_i = lvl[8];
  logic        ct = 1'b1;
  wire         cpu_clk_tick_i = ct;
  wire         sys_div64_tick_i = dv == 3'h0;
  logic [11:0] ri[5] = '{irc_pkg::IDX_PIN0_MOD, irc_pkg::IDX_PIN1_MOD,
    irc_pkg::IDX_ANA_MOD, irc_pkg::IDX_WATCH_ER, irc_pkg::IDX_PRIORITY};
  logic [7:0]  rv[5] = '{8'h0B, 8'h01, 8'h3F, 8'h03, 8'h0F};

  irc_controller uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .basic_timer_interrupt_i,
    .gate_interrupt_i, .watch_interrupt_i, .timer_zero_count_i,
    .timer_zero_reference_i, .pin_interrupt_zero_i, .pin_interrupt_one_i,
    .key_input_i, .comparator_zero_output_i, .comparator_one_output_i,
    .voltage_detect_output_i, .cpu_clk_tick_i, .sys_div64_tick_i,
    .fc_resume_i, .svc_ack_i, .svc_id_i, .irq_o, .irq_id_o, .pending_o,
    .fc_clear_o);
  irc_core_model core (.clk_i, .rst_i, .irq_i(irq_o), .id_i(irq_id_o),
    .delay_i(dly), .ack_o(svc_ack_i), .id_o(svc_id_i));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) dv <= dv + 3'h1;

  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [11:0] i,
                    input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    wb(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [11:0] i, input logic [7:0] e);
    q.push_back({i, e});
    wb(1'b0, i, 8'h00);
  endtask : rd

  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  // Rise then fall on one level input, flag read after each step
  task automatic et(input int s, input logic [11:0] mi,
                    input logic [7:0] mv, input logic [11:0] er,
                    input logic [7:0] m, input logic r, input logic f);
    wr(mi, mv);
    wr(er, 8'h00);
    lvl[s] <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(er, r ? m : 8'h00);
    wr(er, 8'h00);
    lvl[s] <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(er, f ? m : 8'h00);
  endtask : et

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0)
    begin
      n = q.pop_front();
      chk($sformatf("reg %h", n[19:8]), n[7:0], dat_o[7:0]);
    end

  initial
  begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ri[k]) rd(ri[k], 8'h00);
    rd(12'h123, 8'h00);
    foreach (ri[k])
    begin
      wr(ri[k], 8'hFF);
      rd(ri[k], rv[k]);
    end
    wr(ri[3], 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++)
      et(0, ri[0], 8'(m), irc_pkg::IDX_PIN_ER, 8'h01, m % 2 == 0,
         m == 1 || m == 2);
    ct <= 1'b0;
    et(0, ri[0], 8'h00, irc_pkg::IDX_PIN_ER, 8'h01, 0, 0);
    et(0, ri[0], 8'h08, irc_pkg::IDX_PIN_ER, 8'h01, 1, 0);
    ct <= 1'b1;
    for (int m = 0; m < 2; m++)
      et(1, ri[1], 8'(m), irc_pkg::IDX_PIN_ER, 8'h04, m == 0,
         m == 1);
    for (int k = 0; k < 4; k++)
      et(2 + k, irc_pkg::IDX_KEY_MOD, 8'h01 << k, irc_pkg::IDX_KEY_ER,
         8'h01, 0, 1);
    et(2, irc_pkg::IDX_KEY_MOD, 8'h0E, irc_pkg::IDX_KEY_ER, 8'h01, 0,
       0);
    for (int j = 0; j < 3; j++)
      for (int c = 0; c < 4; c++)
        et(j == 0 ? 8 : 5 + j, ri[2], 8'(c << 2 * j), irc_pkg::IDX_ANA_ER,
           8'h01, (c & 2) != 0, (c & 1) != 0);
    $display("test edges done");
    wr(ri[4], 8'h08);
    wr(irc_pkg::IDX_BT_ER, 8'h02);
    wr(irc_pkg::IDX_GATE_ER, 8'h02);
    dly <= 8'hFF;
    pulse(4'h3);
    chk("irq id", 8'h01, {5'h0, irq_id_o});
    chk("pending", 8'h09, pending_o);
    wr(ri[4], 8'h0C);
    repeat (2) @(posedge clk_i);
    chk("irq id", 8'h04, {5'h0, irq_id_o});
    wr(irc_pkg::IDX_STATUS, 8'h04);
    wr(ri[4], 8'h0A);
    repeat (2) @(posedge clk_i);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(ri[4], 8'h0C);
    repeat (2) @(posedge clk_i);
    chk("irq id", 8'h04, {5'h0, irq_id_o});
    wr(irc_pkg::IDX_STATUS, 8'h08);
    repeat (2) @(posedge clk_i);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(irc_pkg::IDX_STATUS, 8'h00);
    dly <= 8'h00;
    repeat (20) @(posedge clk_i);
    rd(irc_pkg::IDX_BT_ER, 8'h02);
    rd(irc_pkg::IDX_GATE_ER, 8'h02);
    wr(ri[4], 8'h00);
    pulse(4'h1);
    chk("pending", 8'h00, pending_o);
    rd(irc_pkg::IDX_BT_ER, 8'h03);
    wr(irc_pkg::IDX_BT_ER, 8'h01);
    wr(ri[4], 8'h08);
    repeat (2) @(posedge clk_i);
    chk("pending", 8'h00, pending_o);
    wr(irc_pkg::IDX_BT_ER, 8'h00);
    $display("test core done");
    wr(ri[3], 8'h02);
    pulse(4'h4);
    repeat (20) @(posedge clk_i);
    chk("pending", 8'h40, pending_o);
    rd(ri[3], 8'h03);
    wr(ri[3], 8'h02);
    rd(ri[3], 8'h02);
    $display("test watch done");
    seed = xs(seed);
    tref <= seed[7:0] | 8'h01;
    wr(irc_pkg::IDX_T0_ER, 8'h00);
    for (int i = 0; i < 256; i++)
      @(posedge clk_i) cnt <= 8'(i);
    @(posedge clk_i) cnt <= tref;
    repeat (3) @(posedge clk_i);
    rd(irc_pkg::IDX_T0_ER, 8'h01);
    wr(irc_pkg::IDX_T0_ER, 8'h00);
    repeat (3) @(posedge clk_i);
    rd(irc_pkg::IDX_T0_ER, 8'h00);
    $display("test timer done");
    wr(irc_pkg::IDX_GATE_ER, 8'h00);
    pulse(4'h2);
    rd(irc_pkg::IDX_GATE_ER, 8'h01);
    wr(irc_pkg::IDX_FC_START, 8'h08);
    @(posedge clk_i);
    chk("fc clear", 8'h01, {7'h0, fc_clear_o});
    rd(irc_pkg::IDX_GATE_ER, 8'h00);
    pulse(4'h8);
    chk("fc clear", 8'h00, {7'h0, fc_clear_o});
    $display("test gate done");
    repeat (3) @(posedge clk_i);
    complete_run();
  end
endmodule : testbench

bind irc_controller irc_controller_props u_props (.clk_i, .rst_i, .cyc_i,
  .stb_i, .basic_timer_interrupt_i, .svc_ack_i, .svc_id_i, .dat_o, .ack_o,
  .irq_o, .irq_id_o, .pending_o);
